// ===== hw/rbsw_params.svh
// constants for the boot store and watchdog block
`ifndef RBSW_PARAMS_SVH
`define RBSW_PARAMS_SVH
`define RBSW_CLK_NS 10
`define RBSW_TICK_NS 1000000
`define RBSW_TICK_CYC (`RBSW_TICK_NS / `RBSW_CLK_NS)
`define RBSW_STEP_MS 16
`define RBSW_DEF_STRAP 4'h5
`define RBSW_NIB_NS 200
`define RBSW_NIB_CYC ((`RBSW_NIB_NS + `RBSW_CLK_NS - 1) / `RBSW_CLK_NS)
`define RBSW_SYNC_NS 300
`define RBSW_SYNC_CYC ((`RBSW_SYNC_NS + `RBSW_CLK_NS - 1) / `RBSW_CLK_NS)
`define RBSW_CLR_BIT 10
`define RBSW_START_CMD 8'h40
`define RBSW_ADDR_W 12
`endif

// ===== hw/rbsw_pkg.sv
// types for the boot store and watchdog block
package rbsw_pkg;
	typedef enum logic [2:0] {st_idle, st_lead, st_wait_trail, st_trail, st_sync} rbsw_fetch_t;
	typedef struct packed
	{
		logic unit_off_switch;
		logic manual_restart_switch;
		logic watchdog_arm_switch;
	} rbsw_panel_t;
endpackage

// ===== hw/rbsw_top.sv
// boot-program store with watchdog restart timer
`timescale 1ns/1ps
`default_nettype none
`include "rbsw_params.svh"
module rbsw_top #(
	parameter int ROM_COUNT = 16,
	parameter int TICK_CYC = `RBSW_TICK_CYC,
	parameter int NIB_CYC = `RBSW_NIB_CYC,
	parameter int SYNC_CYC = `RBSW_SYNC_CYC
) (
	// clock and system clear
	input wire logic clk_i,
	input wire logic rst_i,
	// host bus strobes, all from outside the clock domain
	input wire logic addr_select_i,
	input wire logic fetch_request_i,
	input wire logic output_command_i,
	input wire logic [7:0] command_byte_i,
	// panel switches and timeout strap
	input wire rbsw_pkg::rbsw_panel_t panel_i,
	input wire logic [3:0] timeout_strap_i,
	// rom array: module select, word address, returned nibble
	output logic [15:0] rom_module_selects_o,
	output logic [7:0] rom_word_address_o,
	input wire logic [3:0] rom_nibble_bus_i,
	// bus answer
	output logic [7:0] bus_data_lines_o,
	output logic bus_data_oe_o,
	output logic sync_reply_o,
	// restart
	output logic system_restart_out_o
);
	// refuse parameter values that the decoder and delay counters cannot hold
	if (ROM_COUNT < 1 || ROM_COUNT > 16 || TICK_CYC < 1 || NIB_CYC < 1 || NIB_CYC > 65535
		|| SYNC_CYC < 1 || SYNC_CYC > 65535)
	begin : g_bad_param
		$error("rbsw_top: unsupported parameter");
	end

	// low 8 bits pick the word, upper 4 the module
	function automatic logic [15:0] module_decode(input logic [11:0] a);
		logic [15:0] d;
		d = 16'h0000;
		if (int'(a[11:8]) < ROM_COUNT)
			d[a[11:8]] = 1'b1;
		return d;
	endfunction

	// two-stage synchronisers for all off-domain inputs
	logic [12:0] sync_a; // first stage
	logic [12:0] sync_b; // second stage
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sync_a <= 13'h0000;
			sync_b <= 13'h0000;
		end
		else
		begin
			sync_a <= {addr_select_i, fetch_request_i, output_command_i, command_byte_i,
				panel_i.unit_off_switch, panel_i.manual_restart_switch};
			sync_b <= sync_a;
		end
	end
	logic sync_c; // arm switch, first stage; strap is a level too
	logic sync_d; // arm switch, second stage
	logic [3:0] strap_a;
	logic [3:0] strap_b;
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sync_c <= 1'b0;
			sync_d <= 1'b0;
			strap_a <= `RBSW_DEF_STRAP;
			strap_b <= `RBSW_DEF_STRAP;
		end
		else
		begin
			sync_c <= panel_i.watchdog_arm_switch;
			sync_d <= sync_c;
			strap_a <= timeout_strap_i;
			strap_b <= strap_a;
		end
	end
	logic sel_s, fr_s, oc_s, off_s, man_s, arm_sw_s;
	logic [7:0] cmd_s;
	assign {sel_s, fr_s, oc_s, cmd_s, off_s, man_s} = sync_b;
	assign arm_sw_s = sync_d;

	// gated strobes: unit must be selected and switched on
	logic gated_fetch_request, gated_command_strobe, oc_prev;
	assign gated_fetch_request = fr_s & sel_s & ~off_s;
	assign gated_command_strobe = oc_s & ~oc_prev & sel_s & ~off_s;

	// fetch sequencer state
	rbsw_pkg::rbsw_fetch_t st, next_st;
	logic [11:0] addr, next_addr; // read address counter
	logic [3:0] nibble_latch_out, next_nibble_latch_out;
	logic [15:0] cnt, next_cnt; // one-shot delay
	logic [7:0] data, next_data;
	logic oe, next_oe, syn, next_syn;
	logic addr_step_pulse, counter_load_pulse;
	assign counter_load_pulse = gated_command_strobe;

	// fetch next state: two steps, latch, byte, delayed sync
	always_comb
	begin
		next_st = st;
		next_nibble_latch_out = nibble_latch_out;
		next_cnt = cnt;
		next_data = data;
		next_oe = oe;
		next_syn = syn;
		addr_step_pulse = 1'b0;
		unique case (st)
			rbsw_pkg::st_idle:
			begin
				if (gated_fetch_request)
				begin
					// capture first nibble then step from leading edge
					next_nibble_latch_out = rom_nibble_bus_i;
					addr_step_pulse = 1'b1;
					next_cnt = 16'(NIB_CYC);
					next_st = rbsw_pkg::st_lead;
				end
			end
			rbsw_pkg::st_lead:
			begin
				// wait for rom to settle on next word
				if (cnt > 16'h0001)
					next_cnt = cnt - 16'h0001;
				else
				begin
					next_data = {nibble_latch_out, rom_nibble_bus_i};
					next_oe = 1'b1;
					next_cnt = 16'(SYNC_CYC);
					next_st = rbsw_pkg::st_sync;
				end
			end
			rbsw_pkg::st_sync:
			begin
				// sync only after byte is on the lines
				if (cnt > 16'h0001)
					next_cnt = cnt - 16'h0001;
				else
				begin
					next_syn = 1'b1;
					next_st = rbsw_pkg::st_wait_trail;
				end
			end
			rbsw_pkg::st_wait_trail:
			begin
				// trailing edge gives the second step
				if (!fr_s)
				begin
					addr_step_pulse = 1'b1;
					next_oe = 1'b0;
					next_syn = 1'b0;
					next_st = rbsw_pkg::st_trail;
				end
			end
			rbsw_pkg::st_trail:
				next_st = rbsw_pkg::st_idle;
		endcase
	end

	// address counter next value
	always_comb
	begin
		next_addr = addr;
		if (counter_load_pulse && (cmd_s[`RBSW_CLR_BIT - 8] || cmd_s == 8'h00))
			next_addr = 12'h000;
		else if (addr_step_pulse)
			next_addr = addr + 12'h001;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st <= rbsw_pkg::st_idle;
			addr <= 12'h000;
			nibble_latch_out <= 4'h0;
			cnt <= 16'h0000;
			data <= 8'h00;
			oe <= 1'b0;
			syn <= 1'b0;
			oc_prev <= 1'b0;
			rom_module_selects_o <= 16'h0000;
			rom_word_address_o <= 8'h00;
		end
		else
		begin
			st <= next_st;
			addr <= next_addr;
			nibble_latch_out <= next_nibble_latch_out;
			cnt <= next_cnt;
			data <= next_data;
			oe <= next_oe;
			syn <= next_syn;
			oc_prev <= oc_s;
			rom_module_selects_o <= module_decode(next_addr);
			rom_word_address_o <= next_addr[7:0];
		end
	end
	assign bus_data_lines_o = data;
	assign bus_data_oe_o = oe;
	assign sync_reply_o = syn;

	// watchdog: tick generator, ms counter, arm and restart flip-flops
	logic tick_run, next_tick_run;
	logic [31:0] tick_cnt, next_tick_cnt;
	logic [8:0] ms_cnt, next_ms_cnt;
	logic watchdog_arm_ff, next_watchdog_arm_ff;
	logic restart_ff, next_restart_ff;
	logic [8:0] limit;
	assign limit = 9'(`RBSW_STEP_MS) * ({5'h00, strap_b} + 9'h001);
	always_comb
	begin
		next_tick_run = tick_run;
		next_tick_cnt = tick_cnt;
		next_ms_cnt = ms_cnt;
		next_watchdog_arm_ff = watchdog_arm_ff;
		next_restart_ff = restart_ff;
		if (gated_command_strobe && cmd_s == `RBSW_START_CMD)
		begin
			next_tick_run = 1'b1;
			next_watchdog_arm_ff = 1'b1;
		end
		if (counter_load_pulse)
		begin
			next_tick_cnt = 32'h0;
			next_ms_cnt = 9'h000;
		end
		else if (tick_run && watchdog_arm_ff)
		begin
			// count whole milliseconds, holding at the timeout so the count never wraps
			if (tick_cnt == 32'(TICK_CYC - 1))
			begin
				next_tick_cnt = 32'h0;
				if (ms_cnt < limit)
					next_ms_cnt = ms_cnt + 9'h001;
			end
			else
				next_tick_cnt = tick_cnt + 32'h1;
		end
		// a timeout that meets a reload in the same cycle still restarts: the set wins
		if (tick_run && watchdog_arm_ff && ms_cnt >= limit && arm_sw_s)
			next_restart_ff = 1'b1;
	end
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tick_run <= 1'b0;
			tick_cnt <= 32'h0;
			ms_cnt <= 9'h000;
			watchdog_arm_ff <= 1'b0;
			restart_ff <= 1'b0;
			system_restart_out_o <= 1'b0;
		end
		else
		begin
			tick_run <= next_tick_run;
			tick_cnt <= next_tick_cnt;
			ms_cnt <= next_ms_cnt;
			watchdog_arm_ff <= next_watchdog_arm_ff;
			restart_ff <= next_restart_ff;
			system_restart_out_o <= next_restart_ff | man_s;
		end
	end

	// checks
	a_sync_after_byte: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(sync_reply_o) |-> bus_data_oe_o) else $error("sync before byte");
	a_two_steps_fetch: assert property (@(posedge clk_i) disable iff (rst_i)
		(st == rbsw_pkg::st_trail && !$past(counter_load_pulse)) |->
		addr == $past(addr) + 12'h001) else $error("second step missing");
	a_manual_restart: assert property (@(posedge clk_i) disable iff (rst_i)
		man_s |=> system_restart_out_o) else $error("manual restart lost");
	a_off_hides_unit: assert property (@(posedge clk_i) disable iff (rst_i)
		(off_s && st == rbsw_pkg::st_idle) |=> st == rbsw_pkg::st_idle) else $error("off unit");
	a_restart_needs_arm: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(restart_ff) |-> $past(arm_sw_s) && $past(watchdog_arm_ff)) else $error("arm");
	a_load_clears_ms: assert property (@(posedge clk_i) disable iff (rst_i)
		counter_load_pulse |=> ms_cnt == 9'h000) else $error("load ignored");
	a_decode_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
		$onehot0(rom_module_selects_o)) else $error("module select");
	a_latch_to_byte: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(bus_data_oe_o) |-> bus_data_lines_o[7:4] == nibble_latch_out) else $error("byte");
	a_clear_on_bit: assert property (@(posedge clk_i) disable iff (rst_i)
		(counter_load_pulse && cmd_s[`RBSW_CLR_BIT - 8]) |=> addr == 12'h000)
		else $error("address not cleared");
endmodule
`default_nettype wire

// ===== test/rbsw_rom_model.sv
// rom array model answering module selects and word address
`timescale 1ns/1ps
`default_nettype none
module rbsw_rom_model (
	// selects from the store
	input wire logic [15:0] sel_i,
	input wire logic [7:0] word_i,
	// nibble back to the store
	output logic [3:0] nib_o
);
	logic [3:0] idx; // number of the selected module
	// sixteen modules of 256 nibbles each; the nibble mixes module and word
	always_comb
	begin
		idx = 4'h0;
		for (int i = 0; i < 16; i++)
			if (sel_i[i])
				idx = 4'(i);
		// no module selected: the bus floats, shown as a flipping pattern
		if (sel_i == 16'h0000)
			nib_o = ~word_i[3:0];
		else
			nib_o = word_i[3:0] ^ word_i[7:4] ^ idx ^ 4'h9;
	end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the boot store and watchdog
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int TICK = 10; // clocks per shortened millisecond
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic sel_in = 1'b0;
	logic req = 1'b0;
	logic oc = 1'b0;
	logic [7:0] cb = 8'h00;
	rbsw_pkg::rbsw_panel_t panel = '0;
	logic [3:0] strap = 4'h5;
	logic [15:0] sel;
	logic [7:0] word;
	logic [3:0] nib_w;
	logic [7:0] data;
	logic oe;
	logic sync;
	logic restart;
	int err_total = 0;
	int comparisons = 0;
	int cycles = 0;
	int addr = 0;
	int tmo;
	int n;
	logic [31:0] seed = 32'h0567D37D;
	// device under test with a short tick
	rbsw_top #(.TICK_CYC(TICK)) dut_u (.clk_i, .rst_i, .addr_select_i(sel_in),
		.fetch_request_i(req), .output_command_i(oc), .command_byte_i(cb),
		.panel_i(panel), .timeout_strap_i(strap), .rom_module_selects_o(sel),
		.rom_word_address_o(word), .rom_nibble_bus_i(nib_w), .bus_data_lines_o(data),
		.bus_data_oe_o(oe), .sync_reply_o(sync), .system_restart_out_o(restart));
	rbsw_rom_model rom_u (.sel_i(sel), .word_i(word), .nib_o(nib_w));
	// clock and hang guard
	initial forever #5 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			err_total++;
			final_report();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// reference nibble at a flat 12-bit address
	function automatic logic [3:0] nib(input int a);
		return 4'(a ^ (a >> 4) ^ (a >> 8) ^ 9);
	endfunction
	task automatic final_report();
		if (err_total == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic do_reset();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		addr = 0;
	endtask
	task automatic cmd(input logic [7:0] b);
		@(posedge clk_i);
		cb <= b;
		oc <= 1'b1;
		repeat (4) @(posedge clk_i);
		oc <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	// one byte read: hold request until sync, then release
	task automatic fetch();
		int k;
		req <= 1'b1;
		k = 0;
		while (sync !== 1'b1 && k < 200)
		begin
			@(negedge clk_i);
			k++;
		end
		chk("sync_seen", 8'h01, {7'h0, sync});
		chk("oe_at_sync", 8'h01, {7'h0, oe});
		chk("byte", {nib(addr), nib(addr + 1)}, data);
		@(posedge clk_i);
		req <= 1'b0;
		addr = (addr + 2) % 4096;
		k = 0;
		while (sync !== 1'b0 && k < 50)
		begin
			@(negedge clk_i);
			k++;
		end
		@(posedge clk_i);
	endtask
	// request that must draw no answer
	task automatic refused();
		repeat (3) @(posedge clk_i);
		req <= 1'b1;
		repeat (60) @(negedge clk_i);
		chk("refused_sync", 8'h00, {7'h0, sync});
		chk("refused_oe", 8'h00, {7'h0, oe});
		@(posedge clk_i);
		req <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask
	task automatic watch(input int lim, output int c);
		c = 0;
		while (restart !== 1'b1 && c < lim)
		begin
			@(negedge clk_i);
			c++;
		end
	endtask
	// main sequence
	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(negedge clk_i);
		chk("restart_clear", 8'h00, {7'h0, restart});
		@(posedge clk_i);
		sel_in <= 1'b1;
		repeat (3) @(posedge clk_i);
		for (n = 0; n < 130; n++)
			fetch();
		seed = lfsr(seed);
		cmd((seed[7:0] & 8'hBB) | 8'h01);
		fetch();
		seed = lfsr(seed);
		cmd((seed[7:0] & 8'hBF) | 8'h04);
		addr = 0;
		fetch();
		fetch();
		do_reset();
		fetch();
		sel_in <= 1'b0;
		refused();
		sel_in <= 1'b1;
		panel.unit_off_switch <= 1'b1;
		refused();
		panel.unit_off_switch <= 1'b0;
		repeat (3) @(posedge clk_i);
		fetch();
		seed = lfsr(seed);
		strap <= {1'b0, seed[2:0]};
		tmo = 16 * TICK * (seed[2:0] + 1);
		panel.watchdog_arm_switch <= 1'b1;
		cmd(8'h40);
		watch(tmo + 40, n);
		chk("restart_time", 8'h01, {7'h0, n >= tmo - 8 && n <= tmo + 4});
		do_reset();
		cmd(8'h40);
		repeat (4)
		begin
			repeat (tmo / 2) @(posedge clk_i);
			cmd(8'h00);
		end
		@(negedge clk_i);
		chk("kept_alive", 8'h00, {7'h0, restart});
		do_reset();
		panel.watchdog_arm_switch <= 1'b0;
		cmd(8'h40);
		watch(tmo + 40, n);
		chk("arm_off", 8'h00, {7'h0, restart});
		@(posedge clk_i);
		panel.manual_restart_switch <= 1'b1;
		repeat (6) @(negedge clk_i);
		chk("manual", 8'h01, {7'h0, restart});
		final_report();
	end
endmodule
`default_nettype wire
